// File: inc/uepr_consts.svh
// Constants for the endpoint interrupt priority router
`ifndef UEPR_CONSTS_SVH
`define UEPR_CONSTS_SVH

// Register byte addresses
`define UEPR_DEVST_ADDR 32'hFFE0C200
`define UEPR_DEVPRI_ADDR 32'hFFE0C22C
`define UEPR_EPST_ADDR 32'hFFE0C230
`define UEPR_EPEN_ADDR 32'hFFE0C234
`define UEPR_EPCLR_ADDR 32'hFFE0C238
`define UEPR_EPSET_ADDR 32'hFFE0C23C
`define UEPR_EPPRI_ADDR 32'hFFE0C240
`define UEPR_DMAST_ADDR 32'hFFE0C250

// Reset values
`define UEPR_EPPRI_RST 32'h00000000
`define UEPR_EPEN_RST 32'h00000000
`define UEPR_DEVPRI_RST 1'h0

// Field positions in the device status word
`define UEPR_DEVST_SLOW_BIT 0
`define UEPR_DEVST_FAST_BIT 1
// Field position of the fast-line select in the device priority word
`define UEPR_DEVPRI_FAST_BIT 0

// Bus encodings
`define UEPR_HTRANS_NONSEQ 2'h2
`define UEPR_HSIZE_WORD 3'h2

`endif

// File: inc/uepr_pkg.sv
// Types for the endpoint interrupt priority router
package uepr_pkg;

  // One-hot register select decoded from the address phase
  typedef enum logic [8:0] {
    REG_NONE   = 9'h001,
    REG_DEVST  = 9'h002,
    REG_DEVPRI = 9'h004,
    REG_EPST   = 9'h008,
    REG_EPEN   = 9'h010,
    REG_EPCLR  = 9'h020,
    REG_EPSET  = 9'h040,
    REG_EPPRI  = 9'h080,
    REG_DMAST  = 9'h100
  } uepr_reg_e;

  typedef logic [31:0] uepr_word_t;

endpackage

// File: design/uepr_sticky_bank.sv
// Bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ps
module uepr_sticky_bank #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic [WIDTH-1:0] clr_vec,
  output logic [WIDTH-1:0] flag_q
);

  // **************************************************
  // Per-bit flags
  // **************************************************
  if (WIDTH < 1) begin : g_bad_width
    $error("uepr_sticky_bank: WIDTH must be at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    // Set wins, clear only when no event arrives
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flag_q[i] <= 1'b0;
      end else if (set_vec[i]) begin
        flag_q[i] <= 1'b1;
      end else if (clr_vec[i]) begin
        flag_q[i] <= 1'b0;
      end
    end
  end

endmodule

// File: design/uepr_router.sv
// Endpoint interrupt priority router with its AHB-Lite register slave
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "uepr_consts.svh"

module uepr_router #(
  parameter int unsigned NUM_EP = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2*NUM_EP-1:0] ep_event,
  output logic fast_endpoint_irq_flag,
  output logic slow_endpoint_irq_flag,
  output logic high_priority_irq_line,
  output logic low_priority_irq_line
);

  localparam int unsigned W = 2 * NUM_EP;

  // **************************************************
  // Parameter check
  // **************************************************
  if (NUM_EP < 1 || NUM_EP > 16) begin : g_bad_num_ep
    $error("uepr_router: NUM_EP must be 1 to 16");
  end

  // **************************************************
  // Bus address phase
  // **************************************************
  uepr_pkg::uepr_reg_e addr_dec;
  uepr_pkg::uepr_reg_e wr_reg_r;
  logic addr_take;
  logic [W-1:0] endpoint_irq_priority_select_r;
  logic [W-1:0] endpoint_irq_enable_r;
  logic device_irq_priority_select_r;
  logic [W-1:0] endpoint_irq_status;
  logic [W-1:0] dma_request_status;
  logic [W-1:0] st_set;
  logic [W-1:0] st_clr;
  logic [W-1:0] dma_set;
  logic [W-1:0] dma_clr;
  logic fast_r;
  logic slow_r;
  logic [31:0] hrdata_r;
  logic [31:0] wr_data;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign addr_take = hsel && hready && (htrans == `UEPR_HTRANS_NONSEQ);

  // Address decode to a one-hot select
  always_comb begin
    case (haddr)
      `UEPR_DEVST_ADDR: addr_dec = uepr_pkg::REG_DEVST;
      `UEPR_DEVPRI_ADDR: addr_dec = uepr_pkg::REG_DEVPRI;
      `UEPR_EPST_ADDR: addr_dec = uepr_pkg::REG_EPST;
      `UEPR_EPEN_ADDR: addr_dec = uepr_pkg::REG_EPEN;
      `UEPR_EPCLR_ADDR: addr_dec = uepr_pkg::REG_EPCLR;
      `UEPR_EPSET_ADDR: addr_dec = uepr_pkg::REG_EPSET;
      `UEPR_EPPRI_ADDR: addr_dec = uepr_pkg::REG_EPPRI;
      `UEPR_DMAST_ADDR: addr_dec = uepr_pkg::REG_DMAST;
      default: addr_dec = uepr_pkg::REG_NONE;
    endcase
  end

  // Capture the target of a word write for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg_r <= uepr_pkg::REG_NONE;
    end else if (hready) begin
      if (addr_take && hwrite && hsize == `UEPR_HSIZE_WORD) begin
        wr_reg_r <= addr_dec;
      end else begin
        wr_reg_r <= uepr_pkg::REG_NONE;
      end
    end
  end

  assign wr_data = hwdata;

  // **************************************************
  // Read data
  // **************************************************
  // Read word is registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      case (addr_dec)
        uepr_pkg::REG_DEVST: begin
          hrdata_r <= 32'h00000000;
          hrdata_r[`UEPR_DEVST_FAST_BIT] <= fast_r;
          hrdata_r[`UEPR_DEVST_SLOW_BIT] <= slow_r;
        end
        uepr_pkg::REG_DEVPRI: begin
          hrdata_r <= 32'h00000000;
          hrdata_r[`UEPR_DEVPRI_FAST_BIT] <= device_irq_priority_select_r;
        end
        uepr_pkg::REG_EPST: hrdata_r <= 32'(endpoint_irq_status);
        uepr_pkg::REG_EPEN: hrdata_r <= 32'(endpoint_irq_enable_r);
        uepr_pkg::REG_DMAST: hrdata_r <= 32'(dma_request_status);
        uepr_pkg::REG_EPPRI: hrdata_r <= 32'h00000000;
        default: hrdata_r <= 32'h00000000;
      endcase
    end
  end

  // **************************************************
  // Software registers
  // **************************************************
  // Routing selection, one bit per event line, two per physical endpoint
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      endpoint_irq_priority_select_r <= W'(`UEPR_EPPRI_RST);
    end else if (wr_reg_r == uepr_pkg::REG_EPPRI) begin
      endpoint_irq_priority_select_r <= wr_data[W-1:0];
    end
  end

  // Endpoint interrupt enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      endpoint_irq_enable_r <= W'(`UEPR_EPEN_RST);
    end else if (wr_reg_r == uepr_pkg::REG_EPEN) begin
      endpoint_irq_enable_r <= wr_data[W-1:0];
    end
  end

  // Device-level choice of line for the fast flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      device_irq_priority_select_r <= `UEPR_DEVPRI_RST;
    end else if (wr_reg_r == uepr_pkg::REG_DEVPRI) begin
      device_irq_priority_select_r <= wr_data[`UEPR_DEVPRI_FAST_BIT];
    end
  end

  // **************************************************
  // Endpoint status and DMA request flags
  // **************************************************
  // Events split by enable; software set and clear strobes
  always_comb begin
    st_set = ep_event & endpoint_irq_enable_r;
    dma_set = ep_event & ~endpoint_irq_enable_r;
    st_clr = '0;
    dma_clr = '0;
    if (wr_reg_r == uepr_pkg::REG_EPSET) begin
      st_set = st_set | wr_data[W-1:0];
    end
    if (wr_reg_r == uepr_pkg::REG_EPCLR) begin
      st_clr = wr_data[W-1:0];
    end
    if (wr_reg_r == uepr_pkg::REG_DMAST) begin
      dma_clr = wr_data[W-1:0];
    end
  end

  uepr_sticky_bank #(.WIDTH(W)) u_ep_status (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_vec(st_set),
    .clr_vec(st_clr),
    .flag_q(endpoint_irq_status)
  );

  uepr_sticky_bank #(.WIDTH(W)) u_dma_status (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_vec(dma_set),
    .clr_vec(dma_clr),
    .flag_q(dma_request_status)
  );

  // **************************************************
  // Fast and slow routing
  // **************************************************
  // Flags are levels that track pending status per selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_r <= 1'b0;
      slow_r <= 1'b0;
    end else begin
      fast_r <= |(endpoint_irq_status &
                  endpoint_irq_priority_select_r);
      slow_r <= |(endpoint_irq_status &
                  ~endpoint_irq_priority_select_r);
    end
  end

  assign fast_endpoint_irq_flag = fast_r;
  assign slow_endpoint_irq_flag = slow_r;

  // Slow flag always on the low line; fast flag as chosen
  assign high_priority_irq_line = fast_r &&
                                  device_irq_priority_select_r;
  assign low_priority_irq_line = slow_r ||
                                 (fast_r && !device_irq_priority_select_r);

  // **************************************************
  // Assertions
  // **************************************************
  logic sel_written_r;

  // Remembers whether the selection has ever been written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_written_r <= 1'b0;
    end else if (wr_reg_r == uepr_pkg::REG_EPPRI) begin
      sel_written_r <= 1'b1;
    end
  end

  property p_fast_route;
    @(posedge hclk) disable iff (!hresetn)
    (|(endpoint_irq_status & endpoint_irq_priority_select_r))
      |=> fast_endpoint_irq_flag;
  endproperty
  a_fast_route: assert property (p_fast_route)
    else $error("fast flag missing for selected pending endpoint");

  property p_slow_route;
    @(posedge hclk) disable iff (!hresetn)
    (|(endpoint_irq_status & ~endpoint_irq_priority_select_r))
      |=> slow_endpoint_irq_flag;
  endproperty
  a_slow_route: assert property (p_slow_route)
    else $error("slow flag missing for unselected pending endpoint");

  property p_mixed_route;
    @(posedge hclk) disable iff (!hresetn)
    ((endpoint_irq_status & endpoint_irq_priority_select_r) != '0 &&
     (endpoint_irq_status & ~endpoint_irq_priority_select_r) != '0)
      |=> (fast_endpoint_irq_flag && slow_endpoint_irq_flag);
  endproperty
  a_mixed_route: assert property (p_mixed_route)
    else $error("fast and slow flags not raised together");

  property p_line_pick;
    @(posedge hclk) disable iff (!hresetn)
    fast_endpoint_irq_flag |->
      (device_irq_priority_select_r ? high_priority_irq_line
                                     : low_priority_irq_line);
  endproperty
  a_line_pick: assert property (p_line_pick)
    else $error("fast flag on wrong interrupt line");

  property p_sel_read_zero;
    @(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && addr_dec == uepr_pkg::REG_EPPRI)
      |=> (hrdata == 32'h00000000);
  endproperty
  a_sel_read_zero: assert property (p_sel_read_zero)
    else $error("selection register read not zero");

  property p_sel_reset;
    @(posedge hclk) disable iff (!hresetn)
    !sel_written_r |-> (endpoint_irq_priority_select_r == '0);
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("selection not clear before first write");

  property p_sel_write;
    @(posedge hclk) disable iff (!hresetn)
    (wr_reg_r == uepr_pkg::REG_EPPRI)
      |=> (endpoint_irq_priority_select_r == $past(hwdata[W-1:0]));
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("selection bits differ from written word");

  property p_enable_gate;
    @(posedge hclk) disable iff (!hresetn)
    (ep_event & ~endpoint_irq_enable_r) != '0
      |=> (($past(ep_event & ~endpoint_irq_enable_r) &
            ~dma_request_status) == '0);
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("disabled endpoint event not sent to DMA status");

  property p_flags_idle;
    @(posedge hclk) disable iff (!hresetn)
    (endpoint_irq_status == '0)
      |=> (!fast_endpoint_irq_flag && !slow_endpoint_irq_flag);
  endproperty
  a_flags_idle: assert property (p_flags_idle)
    else $error("flag raised with no pending endpoint status");

endmodule

// File: sim/tb_top.sv
// Self-checking bench for the endpoint interrupt priority router
`timescale 1ns/1ps
`include "uepr_consts.svh"
module tb_top;
  // ****************
  // Signals
  // ****************
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, ep_event;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic fast_fl, slow_fl, hi_line, lo_line;
  logic cmp_v, cmp_kind, p, f, s;
  uepr_pkg::uepr_word_t exp_q[$];
  uepr_pkg::uepr_word_t got, want, en, ev, sel, st, dm, seed;
  int n_fail, checks_done;

  // ****************
  // Design
  // ****************
  uepr_router #(.NUM_EP(16)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ep_event(ep_event),
    .fast_endpoint_irq_flag(fast_fl), .slow_endpoint_irq_flag(slow_fl),
    .high_priority_irq_line(hi_line), .low_priority_irq_line(lo_line)
  );

  // Clock at 100 MHz
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ****************
  // Helpers
  // ****************
  // Fixed-seed xorshift source
  function automatic uepr_pkg::uepr_word_t xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One single AHB-Lite transfer; a read notes its expected data
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d, input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= `UEPR_HTRANS_NONSEQ;
    // Only the watchdog ends a wait for the slave
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) begin
      exp_q.push_back(d);
      cmp_v <= 1'b1;
    end
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    cmp_v <= 1'b0;
  endtask

  // Notes the expected {high, low, fast, slow} levels for one edge
  task automatic lines(input logic [3:0] e);
    @(posedge hclk);
    exp_q.push_back({28'h0, e});
    cmp_kind <= 1'b1;
    cmp_v <= 1'b1;
    @(posedge hclk);
    cmp_v <= 1'b0;
    cmp_kind <= 1'b0;
  endtask

  // One-cycle event pulse, then time for the flags to follow
  task automatic pulse(input logic [31:0] v);
    @(posedge hclk);
    ep_event <= v;
    @(posedge hclk);
    ep_event <= 32'h00000000;
    repeat (2) @(posedge hclk);
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************
  // Checking
  // ****************
  // Takes the oldest note whenever a watched result appears
  always @(posedge hclk) begin
    if (cmp_v && hreadyout) begin
      got = cmp_kind ? {28'h0, hi_line, lo_line, fast_fl, slow_fl} : hrdata;
      want = exp_q.pop_front();
      checks_done++;
      if (got !== want) begin
        n_fail++;
        $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
    end
    // Every read data phase must end with an OKAY response
    if (cmp_v && hresp !== 1'b0) begin
      n_fail++;
      $display("unexpected at %0t: error response", $time);
    end
  end

  // Watchdog cuts a hang short
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end

  // ****************
  // Stimulus
  // ****************
  initial begin
    seed = 32'h0000002C;
    n_fail = 0;
    checks_done = 0;
    {hsel, hwrite, cmp_v, cmp_kind} = 4'h0;
    {haddr, hwdata, ep_event} = {3{32'h00000000}};
    htrans = 2'h0;
    hsize = `UEPR_HSIZE_WORD;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    lines(4'h0);
    bus(`UEPR_EPPRI_ADDR, 1'b0, 32'h00000000, 3'h2);
    bus(32'hFFE0C2FC, 1'b0, 32'h00000000, 3'h2);
    // Byte write to the selection register is dropped
    bus(`UEPR_EPEN_ADDR, 1'b1, 32'hFFFFFFFF, 3'h2);
    bus(`UEPR_EPPRI_ADDR, 1'b1, 32'hFFFFFFFF, 3'h0);
    pulse(32'h00000001);
    lines(4'h5);
    bus(`UEPR_EPCLR_ADDR, 1'b1, 32'hFFFFFFFF, 3'h2);
    // Walking bit, then random routing, enables and line steering
    for (int k = 0; k < 40; k++) begin
      en = xs();
      ev = xs();
      sel = xs();
      p = seed[3];
      if (k < 32) begin
        en = 32'hFFFFFFFF;
        ev = 32'h00000001 << k;
        sel = (k % 2 == 1) ? ev : ~ev;
      end
      st = ev & en;
      dm = ev & ~en;
      f = |(st & sel);
      s = |(st & ~sel);
      bus(`UEPR_EPEN_ADDR, 1'b1, en, 3'h2);
      bus(`UEPR_EPPRI_ADDR, 1'b1, sel, 3'h2);
      bus(`UEPR_DEVPRI_ADDR, 1'b1, {31'h0, p}, 3'h2);
      pulse(ev);
      bus(`UEPR_EPST_ADDR, 1'b0, st, 3'h2);
      bus(`UEPR_DMAST_ADDR, 1'b0, dm, 3'h2);
      bus(`UEPR_DEVST_ADDR, 1'b0, {30'h0, f, s}, 3'h2);
      bus(`UEPR_EPPRI_ADDR, 1'b0, 32'h00000000, 3'h2);
      lines({f & p, s | (f & ~p), f, s});
      bus(`UEPR_EPCLR_ADDR, 1'b1, 32'hFFFFFFFF, 3'h2);
      bus(`UEPR_DMAST_ADDR, 1'b1, 32'hFFFFFFFF, 3'h2);
      lines(4'h0);
    end
    // Software set, register read-back and both flags on together
    bus(`UEPR_EPPRI_ADDR, 1'b1, 32'h0000FFFF, 3'h2);
    bus(`UEPR_DEVPRI_ADDR, 1'b1, 32'h00000001, 3'h2);
    bus(`UEPR_EPEN_ADDR, 1'b1, 32'h5A5A0F0F, 3'h2);
    bus(`UEPR_EPSET_ADDR, 1'b1, 32'h00010001, 3'h2);
    bus(`UEPR_EPST_ADDR, 1'b0, 32'h00010001, 3'h2);
    bus(`UEPR_EPEN_ADDR, 1'b0, 32'h5A5A0F0F, 3'h2);
    bus(`UEPR_DEVPRI_ADDR, 1'b0, 32'h00000001, 3'h2);
    lines(4'hF);
    // Reset in mid-run returns every endpoint to slow routing
    bus(`UEPR_EPPRI_ADDR, 1'b1, 32'hFFFFFFFF, 3'h2);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(`UEPR_EPEN_ADDR, 1'b1, 32'hFFFFFFFF, 3'h2);
    pulse(32'hFFFFFFFF);
    lines(4'h5);
    end_sim();
  end
endmodule
